// ==== rtl/oss_regs.sv ====
// Notes on behaviour
// [RULE1] reset config picks initial source, divider, frequency
// [RULE2] current source read-only in bits 6:4
// [RULE3] current divider read-only in bits 3:0
// [RULE4] current fields show values after reset
// [RULE5] hold set: defer switch, raise interrupt
// [RULE6] hold clear: flag ready, switch automatically
// [RULE7] hold bit software rw, hardware clears
// [RULE8] bit 6 selects secondary power mode
// [RULE9] done flag when requested equals current
// [RULE10] new-ready only during switch with ready
// [RULE11] ready flag sets, switch next cycle
// [RULE12] per-oscillator ready flags, bits 7 to 2
// [RULE13] pll ready in bit 0 only usable
// [RULE14] frequency select codes 0 to 8
// [RULE15] signed six-bit trim, resets zero
// [RULE16] source codes with reserved values
// [RULE17] divider codes 0 to 9
// [RULE18] current fields change at switch instant
//
// The APB register port and the register addresses were chosen for this implementation.
`include "oss_defines.svh"
`default_nettype none
module oss_regs (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] reset_source_config,
   input wire logic external_osc_ready_in,
   input wire logic fast_internal_ready_in,
   input wire logic medium_internal_ready_in,
   input wire logic low_internal_ready_in,
   input wire logic secondary_osc_ready_in,
   input wire logic converter_osc_ready_in,
   input wire logic pll_enabled_in,
   input wire logic pll_locked_in,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output oss_pkg::oss_src_t current_source_sel,
   output oss_pkg::oss_div_t current_divider,
   output oss_pkg::oss_src_t requested_source,
   output oss_pkg::oss_div_t requested_divider,
   output logic [3:0] internal_freq_code,
   output logic [5:0] freq_trim,
   output logic secondary_power_mode,
   output logic irq
);
   import oss_pkg::*;

   // ==========================================================
   // input synchronisation
   logic [5:0] rdy_raw;
   logic [5:0] rdy_s;
   logic [1:0] pll_raw;
   logic [1:0] pll_s;
   assign rdy_raw = {external_osc_ready_in, fast_internal_ready_in, medium_internal_ready_in,
                     low_internal_ready_in, secondary_osc_ready_in, converter_osc_ready_in};
   assign pll_raw = {pll_enabled_in, pll_locked_in};

   oss_sync #(.W(8)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d({rdy_raw, pll_raw}),
      .q({rdy_s, pll_s})
   );

   // ==========================================================
   // state
   oss_src_t cur_src_r;
   oss_div_t cur_div_r;
   oss_src_t req_src_r;
   oss_div_t req_div_r;
   logic [3:0] frq_r;
   logic [5:0] tun_r;
   logic hold_r;
   logic spwr_r;
   logic init_r;
   logic [1:0] ist_r;
   logic [1:0] imsk_r;
   logic [31:0] prdata_r;
   oss_state_t st_r;
   oss_state_t st_nxt;

   // ==========================================================
   // bus decode
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic wr_lo;
   logic hit_req;
   logic hit_cur;
   logic hit_ctl;
   logic hit_rdy;
   logic hit_frq;
   logic hit_tun;
   logic hit_ist;
   logic hit_imsk;
   logic wr_req;
   logic wr_ctl;
   logic wr_frq;
   logic wr_tun;
   logic wr_ist;
   logic wr_imsk;

   // transfer qualifiers, access phase only
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   // writes land only with the low byte lane enabled
   assign wr_lo = pstrb[0];

   // one hit per mapped word
   assign hit_req = (paddr == `OSS_OFF_REQ);
   assign hit_cur = (paddr == `OSS_OFF_CUR);
   assign hit_ctl = (paddr == `OSS_OFF_CTL);
   assign hit_rdy = (paddr == `OSS_OFF_RDY);
   assign hit_frq = (paddr == `OSS_OFF_FRQ);
   assign hit_tun = (paddr == `OSS_OFF_TUN);
   assign hit_ist = (paddr == `OSS_OFF_IST);
   assign hit_imsk = (paddr == `OSS_OFF_IMSK);
   assign addr_ok = hit_req || hit_cur || hit_ctl || hit_rdy || hit_frq || hit_tun || hit_ist || hit_imsk;

   // per-register write strobes; the current and ready words have none
   assign wr_req = wr_en && wr_lo && hit_req;
   assign wr_ctl = wr_en && wr_lo && hit_ctl;
   assign wr_frq = wr_en && wr_lo && hit_frq;
   assign wr_tun = wr_en && wr_lo && hit_tun;
   assign wr_ist = wr_en && wr_lo && hit_ist;
   assign wr_imsk = wr_en && wr_lo && hit_imsk;

   // zero wait states; unmapped words flag an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // ==========================================================
   // oscillator readiness
   logic pll_rdy;
   logic sel_rdy;
   logic pending;
   logic src_ok;
   assign pll_rdy = pll_s[1] && pll_s[0] && rdy_s[5]; // [RULE13]
   assign pending = (req_src_r != cur_src_r) || (req_div_r != cur_div_r); // [RULE9]

   // ready of the requested source
   always_comb begin
      case (req_src_r) // [RULE16]
         `OSS_SRC_EXT: sel_rdy = rdy_s[5];
         `OSS_SRC_HF: sel_rdy = rdy_s[4];
         `OSS_SRC_LF: sel_rdy = rdy_s[2];
         `OSS_SRC_SEC: sel_rdy = rdy_s[1];
         `OSS_SRC_PLL: sel_rdy = pll_rdy;
         default: sel_rdy = 1'b0;
      endcase
   end

   // reserved source writes are ignored
   always_comb begin
      case (pwdata[6:4])
         `OSS_SRC_RES3, `OSS_SRC_RES1, `OSS_SRC_HF64: src_ok = 1'b0; // [RULE16]
         default: src_ok = 1'b1;
      endcase
   end

   // ==========================================================
   // switch sequencer
   logic do_switch;
   logic nrdy;
   assign nrdy = (st_r == OSS_HOLD) || (st_r == OSS_WAIT && sel_rdy && pending); // [RULE10]
   assign do_switch = (st_r == OSS_WAIT) && pending && sel_rdy && !hold_r; // [RULE6] [RULE11]

   // next state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         OSS_IDLE: begin
            if (pending) begin
               st_nxt = OSS_WAIT;
            end
         end
         OSS_WAIT: begin
            if (!pending || do_switch) begin
               st_nxt = OSS_IDLE;
            end else if (sel_rdy && hold_r) begin
               st_nxt = OSS_HOLD; // [RULE5]
            end
         end
         OSS_HOLD: begin
            if (!pending) begin
               st_nxt = OSS_IDLE;
            end else if (!hold_r || !sel_rdy) begin
               st_nxt = OSS_WAIT;
            end
         end
         default: st_nxt = OSS_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r <= OSS_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // reset defaults caught one edge after release
   always_ff @(posedge core_clk) begin
      if (rst) begin
         init_r <= 1'b1;
      end else begin
         init_r <= 1'b0;
      end
   end

   // current and requested selection
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cur_src_r <= `OSS_SRC_HF;
         cur_div_r <= `OSS_DIV_4;
         req_src_r <= `OSS_SRC_HF;
         req_div_r <= `OSS_DIV_4;
      end else if (init_r) begin
         case (reset_source_config) // [RULE1] [RULE4]
            `OSS_SRC_HF64: begin
               cur_src_r <= `OSS_SRC_HF;
               cur_div_r <= `OSS_DIV_1;
               req_src_r <= `OSS_SRC_HF;
               req_div_r <= `OSS_DIV_1;
            end
            `OSS_SRC_EXT, `OSS_SRC_LF, `OSS_SRC_SEC, `OSS_SRC_PLL: begin
               cur_src_r <= reset_source_config;
               cur_div_r <= `OSS_DIV_1;
               req_src_r <= reset_source_config;
               req_div_r <= `OSS_DIV_1;
            end
            default: begin
               cur_src_r <= `OSS_SRC_HF;
               cur_div_r <= `OSS_DIV_4;
               req_src_r <= `OSS_SRC_HF;
               req_div_r <= `OSS_DIV_4;
            end
         endcase
      end else begin
         if (do_switch) begin
            cur_src_r <= req_src_r; // [RULE18]
            cur_div_r <= req_div_r;
         end
         if (wr_req && src_ok && pwdata[3:0] <= `OSS_DIV_MAX) begin
            req_src_r <= pwdata[6:4]; // [RULE17]
            req_div_r <= pwdata[3:0];
         end
      end
   end

   // frequency select
   always_ff @(posedge core_clk) begin
      if (rst) begin
         frq_r <= `OSS_FRQ_4M;
      end else if (init_r) begin
         frq_r <= (reset_source_config == `OSS_SRC_HF64) ? `OSS_FRQ_64M : `OSS_FRQ_4M; // [RULE1]
      end else if (wr_frq && pwdata[3:0] <= `OSS_FRQ_MAX) begin
         frq_r <= pwdata[3:0]; // [RULE14]
      end
   end

   // trim
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tun_r <= 6'h00; // [RULE15]
      end else if (wr_tun) begin
         tun_r <= pwdata[5:0]; // [RULE15]
      end
   end

   // hold and power mode
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hold_r <= 1'b0; // [RULE7]
         spwr_r <= 1'b0; // [RULE8]
      end else if (wr_ctl) begin
         hold_r <= pwdata[`OSS_CTL_HOLD]; // [RULE7]
         spwr_r <= pwdata[`OSS_CTL_SPWR]; // [RULE8]
      end else if (!pending) begin
         hold_r <= 1'b0; // [RULE7]
      end
   end

   // ==========================================================
   // interrupts: set wins over write-one clear
   logic [1:0] ev;
   assign ev[`OSS_IRQ_SW] = (st_r == OSS_WAIT) && (st_nxt == OSS_HOLD); // [RULE5]
   assign ev[`OSS_IRQ_DONE] = do_switch;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ist_r <= 2'h0;
      end else if (wr_ist) begin
         ist_r <= (ist_r & ~pwdata[1:0]) | ev;
      end else begin
         ist_r <= ist_r | ev;
      end
   end

   // mask
   always_ff @(posedge core_clk) begin
      if (rst) begin
         imsk_r <= 2'h0;
      end else if (wr_imsk) begin
         imsk_r <= pwdata[1:0];
      end
   end

   assign irq = |(ist_r & imsk_r);

   // ==========================================================
   // read views of the status words
   logic [7:0] ctl_view;
   logic [7:0] rdy_view;
   // control word: hold, power, done, new-ready
   assign ctl_view = {hold_r, spwr_r, 1'b0, !pending, nrdy, 3'h0}; // [RULE9] [RULE10]
   // ready word: bit 1 is unused and reads zero
   assign rdy_view = {rdy_s, 1'b0, pll_rdy}; // [RULE12] [RULE13]

   // ==========================================================
   // read data, captured in the setup cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `OSS_OFF_REQ: prdata_r <= {25'h000_0000, req_src_r, req_div_r};
            `OSS_OFF_CUR: prdata_r <= {25'h000_0000, cur_src_r, cur_div_r}; // [RULE2] [RULE3]
            `OSS_OFF_CTL: prdata_r <= {24'h00_0000, ctl_view}; // [RULE9] [RULE10]
            `OSS_OFF_RDY: prdata_r <= {24'h00_0000, rdy_view}; // [RULE12] [RULE13]
            `OSS_OFF_FRQ: prdata_r <= {28'h000_0000, frq_r};
            `OSS_OFF_TUN: prdata_r <= {26'h000_0000, tun_r};
            `OSS_OFF_IST: prdata_r <= {30'h0000_0000, ist_r};
            `OSS_OFF_IMSK: prdata_r <= {30'h0000_0000, imsk_r};
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // read data shows only in the access cycle of a read
   assign prdata = rd_en ? prdata_r : 32'h0000_0000;
   // field outputs straight from their registers
   assign current_source_sel = cur_src_r;
   assign current_divider = cur_div_r;
   assign requested_source = req_src_r;
   assign requested_divider = req_div_r;
   assign internal_freq_code = frq_r;
   assign freq_trim = tun_r;
   assign secondary_power_mode = spwr_r;
endmodule // oss_regs
`default_nettype wire

// ==== rtl/oss_defines.svh ====
`ifndef OSS_DEFINES_SVH
`define OSS_DEFINES_SVH
// ==========================================================
// register byte offsets
`define OSS_OFF_REQ 12'h000
`define OSS_OFF_CUR 12'h004
`define OSS_OFF_CTL 12'h008
`define OSS_OFF_RDY 12'h00C
`define OSS_OFF_FRQ 12'h010
`define OSS_OFF_TUN 12'h014
`define OSS_OFF_IST 12'h018
`define OSS_OFF_IMSK 12'h01C
// ==========================================================
// source codes
`define OSS_SRC_EXT 3'h7
`define OSS_SRC_HF 3'h6
`define OSS_SRC_LF 3'h5
`define OSS_SRC_SEC 3'h4
`define OSS_SRC_RES3 3'h3
`define OSS_SRC_PLL 3'h2
`define OSS_SRC_RES1 3'h1
`define OSS_SRC_HF64 3'h0
// ==========================================================
// divider and frequency codes
`define OSS_DIV_1 4'h0
`define OSS_DIV_4 4'h2
`define OSS_DIV_MAX 4'h9
`define OSS_FRQ_4M 4'h2
`define OSS_FRQ_64M 4'h8
`define OSS_FRQ_MAX 4'h8
// ==========================================================
// bit positions
`define OSS_CTL_HOLD 7
`define OSS_CTL_SPWR 6
`define OSS_CTL_DONE 4
`define OSS_CTL_NRDY 3
`define OSS_IRQ_SW 0
`define OSS_IRQ_DONE 1
`endif

// ==== rtl/oss_pkg.sv ====
`default_nettype none
package oss_pkg;
   typedef logic [2:0] oss_src_t;
   typedef logic [3:0] oss_div_t;
   typedef enum logic [2:0] {
      OSS_IDLE = 3'b001,
      OSS_WAIT = 3'b010,
      OSS_HOLD = 3'b100
   } oss_state_t;
endpackage
`default_nettype wire

// ==== rtl/oss_sync.sv ====
`default_nettype none
// ==========================================================
// two-flop synchroniser per bit
module oss_sync #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   // first stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // oss_sync
`default_nettype wire

// ==== tb/oss_regs_props.sv ====
`include "oss_defines.svh"
`default_nettype none
module oss_regs_props (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire oss_pkg::oss_src_t current_source_sel,
   input wire oss_pkg::oss_div_t current_divider,
   input wire oss_pkg::oss_src_t requested_source,
   input wire oss_pkg::oss_div_t requested_divider,
   input wire logic [3:0] internal_freq_code,
   input wire logic [5:0] freq_trim,
   input wire logic secondary_power_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   import oss_pkg::*;
   logic [1:0] up_r;
   logic acc;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ====
   // settle count after reset release
   always_ff @(posedge core_clk) begin
      if (rst) begin
         up_r <= 2'h0;
      end else if (up_r != 2'h2) begin
         up_r <= up_r + 2'h1;
      end
   end
   // access phase
   assign acc = psel && penable;
   // ====
   // properties
   cur_follow_a: assert property (
      up_r == 2'h2 && !$stable({current_source_sel, current_divider}) |->
      {current_source_sel, current_divider} == $past({requested_source, requested_divider}))
      else $error("current fields moved without switch");
   cur_ro_a: assert property (
      acc && pwrite && paddr == `OSS_OFF_CUR |=> $stable({current_source_sel, current_divider}) ||
      {current_source_sel, current_divider} == $past({requested_source, requested_divider}))
      else $error("current fields written");
   cur_read_a: assert property (
      acc && !pwrite && paddr == `OSS_OFF_CUR |->
      prdata == {25'h000_0000, $past(current_source_sel), $past(current_divider)})
      else $error("current read wrong");
   done_bit_a: assert property (
      acc && !pwrite && paddr == `OSS_OFF_CTL |-> prdata[4] ==
      ($past({requested_source, requested_divider}) == $past({current_source_sel, current_divider})))
      else $error("done flag wrong");
   req_legal_a: assert property (
      !(requested_source inside {3'h3, 3'h1, 3'h0}) && requested_divider <= 4'h9)
      else $error("reserved request held");
   frq_legal_a: assert property (internal_freq_code <= 4'h8)
      else $error("reserved frequency held");
   trim_wr_a: assert property (
      acc && pwrite && pstrb[0] && paddr == `OSS_OFF_TUN |=> freq_trim == $past(pwdata[5:0]))
      else $error("trim not written");
   power_wr_a: assert property (
      acc && pwrite && pstrb[0] && paddr == `OSS_OFF_CTL |=> secondary_power_mode == $past(pwdata[6]))
      else $error("power mode not written");
endmodule // oss_regs_props
bind oss_regs oss_regs_props i_oss_regs_props (.core_clk, .rst, .paddr, .psel, .penable, .pwrite,
   .pwdata, .pstrb, .prdata, .current_source_sel, .current_divider, .requested_source,
   .requested_divider, .internal_freq_code, .freq_trim, .secondary_power_mode);
`default_nettype wire

// ==== tb/test_oss_regs.sv ====
`include "oss_defines.svh"
`default_nettype none
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module test_oss_regs;
   timeunit 1ns;
   timeprecision 1ns;
   import oss_pkg::*;
   typedef struct {string n; logic [31:0] e;} oss_note_t;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] reset_source_config = 3'h6;
   logic [7:0] rdy = 8'hFF;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic want = 1'b0;
   logic [31:0] prdata, last_rd;
   logic pready, pslverr, secondary_power_mode, irq;
   oss_src_t current_source_sel, requested_source;
   oss_div_t current_divider, requested_divider;
   logic [3:0] internal_freq_code;
   logic [5:0] freq_trim;
   logic [7:0] v;
   oss_note_t notes[$];
   oss_note_t nt;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   int seed = 9929;
   always #5 core_clk = ~core_clk;
   oss_regs i_oss_regs (.core_clk, .rst, .reset_source_config, .external_osc_ready_in(rdy[7]),
      .fast_internal_ready_in(rdy[6]), .medium_internal_ready_in(rdy[5]), .low_internal_ready_in(rdy[4]),
      .secondary_osc_ready_in(rdy[3]), .converter_osc_ready_in(rdy[2]), .pll_enabled_in(rdy[1]),
      .pll_locked_in(rdy[0]), .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .current_source_sel, .current_divider, .requested_source, .requested_divider, .internal_freq_code,
      .freq_trim, .secondary_power_mode, .irq);
   // ====
   // bus tasks
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic c);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      want <= c;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      want <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(a, 1'b1, {24'h00_0000, d}, 1'b0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
      notes.push_back('{n, {24'h00_0000, e}});
      apb(a, 1'b0, 32'h0000_0000, 1'b1);
   endtask
   task automatic poll(input logic [11:0] a, input int b);
      for (int i = 0; i < 40; i++) begin
         apb(a, 1'b0, 32'h0000_0000, 1'b0);
         if (last_rd[b] === 1'b1) break;
      end
   endtask
   task automatic chk_irq(input logic e);
      @(negedge core_clk);
      `CK("irq", e, irq)
      @(posedge core_clk);
   endtask
   task automatic do_rst(input logic [2:0] c, input int n);
      reset_source_config <= c;
      rst <= 1'b1;
      repeat (n) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   function automatic logic [7:0] strap_cur(input logic [2:0] c);
      if (c == 3'h0) return 8'h60;
      if (c inside {3'h7, 3'h5, 3'h4, 3'h2}) return {1'b0, c, 4'h0};
      return 8'h62;
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ====
   // read monitor, compares oldest note
   always @(negedge core_clk) begin
      if (psel && penable) begin
         `CK("pready", 1'b1, pready)
         `CK("pslverr", (paddr > `OSS_OFF_IMSK), pslverr)
      end
      if (psel && penable && !pwrite) begin
         last_rd = prdata;
         if (want && notes.size() > 0) begin
            nt = notes.pop_front();
            `CK(nt.n, nt.e, prdata)
         end
      end
   end
   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end
   // ====
   // main sequence
   initial begin
      for (int c = 0; c < 8; c++) begin
         do_rst(c[2:0], (c == 0) ? 16 : 2);
         rd(`OSS_OFF_CUR, strap_cur(c[2:0]), "cur");
         rd(`OSS_OFF_REQ, strap_cur(c[2:0]), "req");
         rd(`OSS_OFF_FRQ, (c == 0) ? 8'h08 : 8'h02, "frq");
         rd(`OSS_OFF_CTL, 8'h10, "ctl");
         rd(`OSS_OFF_TUN, 8'h00, "tun");
      end
      $display("test strap done");
      do_rst(3'h6, 2);
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 8'h20 : (k == 1) ? 8'h1F : 8'($random(seed));
         wr(`OSS_OFF_TUN, v);
         rd(`OSS_OFF_TUN, {2'h0, v[5:0]}, "tun");
      end
      v = 8'h02;
      for (int k = 0; k < 16; k++) begin
         wr(`OSS_OFF_FRQ, 8'(k));
         if (k <= 8) v = 8'(k);
         rd(`OSS_OFF_FRQ, v, "frq");
      end
      wr(`OSS_OFF_CUR, 8'h7F);
      rd(`OSS_OFF_CUR, 8'h62, "cur ro");
      wr(`OSS_OFF_REQ, 8'h31);
      wr(`OSS_OFF_REQ, 8'h5A);
      rd(`OSS_OFF_REQ, 8'h62, "req rsv");
      rd(12'h020, 8'h00, "unmapped");
      $display("test regs done");
      wr(`OSS_OFF_REQ, 8'h53);
      poll(`OSS_OFF_CTL, 4);
      rd(`OSS_OFF_CUR, 8'h53, "cur sw");
      rd(`OSS_OFF_CTL, 8'h10, "ctl sw");
      rd(`OSS_OFF_IST, 8'h02, "ist sw");
      wr(`OSS_OFF_IST, 8'h03);
      $display("test switch done");
      rdy <= 8'h7F;
      wr(`OSS_OFF_REQ, 8'h70);
      wr(`OSS_OFF_CTL, 8'hC0);
      rd(`OSS_OFF_CTL, 8'hC0, "ctl hold");
      wr(`OSS_OFF_IMSK, 8'h01);
      rdy <= 8'hFF;
      poll(`OSS_OFF_CTL, 3);
      rd(`OSS_OFF_CUR, 8'h53, "cur held");
      rd(`OSS_OFF_IST, 8'h01, "ist held");
      chk_irq(1'b1);
      wr(`OSS_OFF_CTL, 8'h40);
      poll(`OSS_OFF_CTL, 4);
      rd(`OSS_OFF_CUR, 8'h70, "cur new");
      rd(`OSS_OFF_CTL, 8'h50, "ctl new");
      wr(`OSS_OFF_IST, 8'h03);
      chk_irq(1'b0);
      $display("test hold done");
      for (int k = 0; k < 6; k++) begin
         v = 8'($random(seed));
         rdy <= v;
         repeat (4) @(posedge core_clk);
         rd(`OSS_OFF_RDY, {v[7:2], 1'b0, v[7] & v[1] & v[0]}, "rdy");
      end
      $display("test ready done");
      tally_and_finish();
   end
endmodule // test_oss_regs
`default_nettype wire
